/* File: csm_regs.sv */
// Core special registers: exception number, state bit, priority mask
// and stack select, with boot vector load and restart bookkeeping.
// Assumes the core pipeline drives the strobes one cycle at a time.
//
// How it works
// - Exception number field in bits 5..0 shows the active exception.
// - Execution state word holds only the state bit at position 24.
// - Software reads of the execution state word return zero.
// - Software writes to the execution state word are dropped.
// - Exception entry stacks the true state bit in the status word.
// - State bit loads from branch exchange, return, and entry vector.
// - Executing with state bit zero raises hard fault or lockup.
// - Interrupt during load or store multiple abandons that instruction.
// - Abandoned multiple transfer restarts from its first transfer.
// - Mask bit set blocks all configurable-priority exceptions.
// - Mask bit is moved by special register moves and state change.
// - Control bit 1 picks process (1) or main (0) stack in thread mode.
// - In handler mode stack select reads zero and ignores writes.
// - Handler mode always uses the main stack pointer.
// - Entry and return update the control register themselves.
// - Thread mode uses the main stack until software selects otherwise.
// - Every exception except reset runs in handler mode.
// - Word, halfword and byte data accesses are supported.
// - All data, fetch and private bus accesses are little-endian.
// - Reset loads main stack pointer from address zero, thread mode.
// - Reset loads program counter from address four, bit 0 to state.
`timescale 1ns/1ps
`include "csm_regs_map.svh"

module csm_regs
  import csm_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  // Special register moves
  input  wire logic        SR_RD,
  input  wire logic        SR_WR,
  input  wire logic [2:0]  SR_SEL,
  input  wire logic [31:0] SR_WDATA,
  output logic      [31:0] SR_RDATA,
  output logic             SR_RVALID,
  // Change processor state
  input  wire logic        CPS_EN,
  input  wire logic        CPS_DISABLE,
  // Exception entry and return
  input  wire logic        EXC_ENTRY,
  input  wire logic [5:0]  EXC_NUM,
  input  wire logic        VECTOR_BIT0,
  input  wire logic        EXC_RETURN,
  input  wire logic [31:0] RET_PSR,
  input  wire logic        RET_TO_THREAD,
  input  wire logic        RET_SP_SEL,
  output logic      [31:0] STACKED_PSR,
  // Branch exchange and pop into program counter
  input  wire logic        BX_LOAD,
  input  wire logic        BX_TBIT,
  // Instruction issue check
  input  wire logic        INSTR_EXEC,
  output logic             HARD_FAULT_REQ,
  output logic             LOCKUP,
  // Exception gating by the priority mask
  input  wire logic        EXC_REQ,
  input  wire logic        EXC_PRIO_CFG,
  output logic             EXC_ALLOW,
  // Load and store multiple restart
  input  wire logic        MULT_BUSY,
  input  wire logic [31:0] MULT_PC,
  input  wire logic        IRQ_TAKEN,
  output logic             MULT_ABANDON,
  output logic      [31:0] STACKED_RET_PC,
  output logic             RESTART_FIRST,
  // Boot vector fetch
  output logic             BOOT_REQ,
  output logic      [31:0] BOOT_ADDR,
  input  wire logic        BOOT_ACK,
  input  wire logic [31:0] BOOT_RDATA,
  output logic             MAIN_SP_LOAD,
  output logic             PC_LOAD,
  output logic      [31:0] BOOT_VALUE,
  // Data load lanes
  input  wire logic        DATA_RD,
  input  wire logic [31:0] DATA_WORD,
  input  wire logic [1:0]  DATA_ADDR,
  input  wire logic [1:0]  DATA_SIZE,
  output logic      [31:0] DATA_VALUE,
  // Status views
  output logic             HANDLER_MODE,
  output logic             PROCESS_SP,
  output logic             MASK_ACTIVE,
  output logic             T_STATE
);

  csm_boot_t   boot_state;
  csm_mode_t   mode;
  logic [5:0]  exc_num;
  logic        tbit;
  logic        prio_mask;
  logic        stack_sel;
  logic        mult_pending;
  logic [31:0] lane_value;
  logic        running;
  logic        next_tbit;
  logic [31:0] rd_word;

  assign running = (boot_state == CSM_RUN);

  // Boot sequence: stack pointer word, then reset vector
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      boot_state   <= CSM_BOOT_SP;
      BOOT_REQ     <= 1'h0;
      BOOT_ADDR    <= `CSM_VEC_SP_ADDR;
      MAIN_SP_LOAD <= 1'h0;
      PC_LOAD      <= 1'h0;
      BOOT_VALUE   <= 32'h0000_0000;
    end
    else
    begin
      MAIN_SP_LOAD <= 1'h0;
      PC_LOAD      <= 1'h0;
      unique case (boot_state)
        CSM_BOOT_SP:
        begin
          BOOT_REQ  <= 1'h1;
          BOOT_ADDR <= `CSM_VEC_SP_ADDR;
          if (BOOT_REQ && BOOT_ACK)
          begin
            MAIN_SP_LOAD <= 1'h1;
            BOOT_VALUE   <= BOOT_RDATA;
            BOOT_ADDR    <= `CSM_VEC_PC_ADDR;
            boot_state   <= CSM_BOOT_PC;
          end
        end
        CSM_BOOT_PC:
        begin
          if (BOOT_REQ && BOOT_ACK)
          begin
            PC_LOAD    <= 1'h1;
            BOOT_VALUE <= BOOT_RDATA;
            BOOT_REQ   <= 1'h0;
            boot_state <= CSM_RUN;
          end
        end
        CSM_RUN:
        begin
          BOOT_REQ <= 1'h0;
        end
      endcase
    end
  end

  // Mode and exception number; software moves never reach this
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mode    <= CSM_MODE_THREAD;
      exc_num <= `CSM_RST_EXC;
    end
    else if (EXC_ENTRY && running)
    begin
      mode    <= CSM_MODE_HANDLER;
      exc_num <= EXC_NUM;
    end
    else if (EXC_RETURN && running)
    begin
      mode    <= RET_TO_THREAD ? CSM_MODE_THREAD : CSM_MODE_HANDLER;
      exc_num <= RET_TO_THREAD ? `CSM_EXC_THREAD
                               : RET_PSR[`CSM_EXC_MSB:0];
    end
  end

  // State bit sources; return and entry outrank a branch
  always_comb
  begin
    next_tbit = tbit;
    if (boot_state == CSM_BOOT_PC && BOOT_REQ && BOOT_ACK)
    begin
      next_tbit = BOOT_RDATA[0];
    end
    else if (EXC_ENTRY)
    begin
      next_tbit = VECTOR_BIT0;
    end
    else if (EXC_RETURN)
    begin
      next_tbit = RET_PSR[`CSM_TBIT_POS];
    end
    else if (BX_LOAD)
    begin
      next_tbit = BX_TBIT;
    end
  end

  // Software moves cannot touch the state bit
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tbit <= `CSM_RST_TBIT;
    end
    else
    begin
      tbit <= next_tbit;
    end
  end

  // Priority mask: special register move or state change
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prio_mask <= `CSM_RST_MASK;
    end
    else if (CPS_EN)
    begin
      prio_mask <= CPS_DISABLE;
    end
    else if (SR_WR && SR_SEL == `CSM_SEL_PRIO_MASK)
    begin
      prio_mask <= SR_WDATA[`CSM_MASK_POS];
    end
  end

  // Stack select; handler writes dropped, return restores thread choice
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      stack_sel <= `CSM_RST_SPSEL;
    end
    else if (EXC_ENTRY)
    begin
      stack_sel <= 1'h0;
    end
    else if (EXC_RETURN && RET_TO_THREAD)
    begin
      stack_sel <= RET_SP_SEL;
    end
    else if (SR_WR && SR_SEL == `CSM_SEL_STACK_CTRL
             && mode == CSM_MODE_THREAD)
    begin
      stack_sel <= SR_WDATA[`CSM_SPSEL_POS];
    end
  end

  // Read mux; execution state bits always read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (SR_SEL)
      `CSM_SEL_INTR_STATUS:
        rd_word[`CSM_EXC_MSB:0] = exc_num;
      `CSM_SEL_EXEC_STATE:
        rd_word = 32'h0000_0000;
      `CSM_SEL_PROG_STATUS:
        rd_word[`CSM_EXC_MSB:0] = exc_num;
      `CSM_SEL_PRIO_MASK:
        rd_word[`CSM_MASK_POS] = prio_mask;
      `CSM_SEL_STACK_CTRL:
        rd_word[`CSM_SPSEL_POS] = (mode == CSM_MODE_THREAD)
                                  & stack_sel;
      default:
        rd_word = 32'h0000_0000; // Unused selectors read zero
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SR_RDATA  <= 32'h0000_0000;
      SR_RVALID <= 1'h0;
    end
    else
    begin
      SR_RVALID <= SR_RD;
      if (SR_RD)
      begin
        SR_RDATA <= rd_word;
      end
    end
  end

  // Stacked status carries the true state bit for fault handlers
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      STACKED_PSR <= 32'h0000_0000;
    end
    else if (EXC_ENTRY && running)
    begin
      STACKED_PSR                  <= 32'h0000_0000;
      STACKED_PSR[`CSM_TBIT_POS]   <= tbit;
      STACKED_PSR[`CSM_EXC_MSB:0]  <= exc_num;
    end
  end

  // State bit check on issue: fault, or lockup if in the hard fault or NMI handler
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      HARD_FAULT_REQ <= 1'h0;
      LOCKUP         <= 1'h0;
    end
    else
    begin
      HARD_FAULT_REQ <= 1'h0;
      if (INSTR_EXEC && running && !tbit && !LOCKUP)
      begin
        if (mode == CSM_MODE_HANDLER
            && (exc_num == `CSM_EXC_HARD_FAULT
                || exc_num == `CSM_EXC_NMI))
        begin
          LOCKUP <= 1'h1;
        end
        else
        begin
          HARD_FAULT_REQ <= 1'h1;
        end
      end
    end
  end

  // Mask gate; fixed-priority exceptions pass regardless
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      EXC_ALLOW <= 1'h0;
    end
    else
    begin
      EXC_ALLOW <= EXC_REQ && !(EXC_PRIO_CFG && prio_mask);
    end
  end

  // Multiple transfer abandon and restart from the first beat
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      MULT_ABANDON    <= 1'h0;
      STACKED_RET_PC  <= 32'h0000_0000;
      mult_pending    <= 1'h0;
      RESTART_FIRST   <= 1'h0;
    end
    else
    begin
      MULT_ABANDON  <= 1'h0;
      RESTART_FIRST <= 1'h0;
      // Only the outermost return replays the transfer
      if (EXC_RETURN && RET_TO_THREAD && mult_pending)
      begin
        RESTART_FIRST <= 1'h1;
        mult_pending  <= 1'h0;
      end
      // A fresh abandon in the same cycle outranks the replay's clear
      if (IRQ_TAKEN && MULT_BUSY)
      begin
        MULT_ABANDON   <= 1'h1;
        STACKED_RET_PC <= MULT_PC;
        mult_pending   <= 1'h1;
      end
    end
  end

  // Byte lanes picked in little-endian order
  csm_le_lane u_lane
  (
    .word  (DATA_WORD),
    .addr  (DATA_ADDR),
    .size  (DATA_SIZE),
    .value (lane_value)
  );

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      DATA_VALUE <= 32'h0000_0000;
    end
    else if (DATA_RD)
    begin
      DATA_VALUE <= lane_value;
    end
  end

  // Status views; handler mode forces the main stack
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      HANDLER_MODE <= 1'h0;
      PROCESS_SP   <= 1'h0;
      MASK_ACTIVE  <= 1'h0;
      T_STATE      <= 1'h0;
    end
    else
    begin
      HANDLER_MODE <= (mode == CSM_MODE_HANDLER);
      PROCESS_SP   <= (mode == CSM_MODE_THREAD) && stack_sel;
      MASK_ACTIVE  <= prio_mask;
      T_STATE      <= tbit;
    end
  end

endmodule

/* File: csm_regs_map.svh */
// Constants for the core status, mask and control register group.
// Included by name by the package and the design files.
`ifndef CSM_REGS_MAP_SVH
`define CSM_REGS_MAP_SVH

// Special register selectors
`define CSM_SEL_INTR_STATUS 3'h0
`define CSM_SEL_EXEC_STATE  3'h1
`define CSM_SEL_PROG_STATUS 3'h2
`define CSM_SEL_PRIO_MASK   3'h3
`define CSM_SEL_STACK_CTRL  3'h4

// Field positions and widths
`define CSM_EXC_MSB         5
`define CSM_TBIT_POS        24
`define CSM_MASK_POS        0
`define CSM_SPSEL_POS       1

// Exception numbers
`define CSM_EXC_THREAD      6'h00
`define CSM_EXC_NMI         6'h02
`define CSM_EXC_HARD_FAULT  6'h03
`define CSM_EXC_SVC         6'h0B
`define CSM_EXC_PEND_SVC    6'h0E
`define CSM_EXC_SYS_TICK    6'h0F
`define CSM_EXC_IRQ_FIRST   6'h10
`define CSM_EXC_IRQ_LAST    6'h2F

// Reset values and boot vector addresses
`define CSM_RST_EXC         6'h00
`define CSM_RST_MASK        1'h0
`define CSM_RST_SPSEL       1'h0
`define CSM_RST_TBIT        1'h0
`define CSM_VEC_SP_ADDR     32'h0000_0000
`define CSM_VEC_PC_ADDR     32'h0000_0004

// Access sizes
`define CSM_SIZE_BYTE       2'h0
`define CSM_SIZE_HALF       2'h1
`define CSM_SIZE_WORD       2'h2

`endif

/* File: csm_pkg.sv */
// Types shared by the register group and its lane extractor.
// Relies on csm_regs_map.svh for all numeric constants.
`include "csm_regs_map.svh"

package csm_pkg;

  typedef enum logic [1:0]
  {
    CSM_BOOT_SP,
    CSM_BOOT_PC,
    CSM_RUN
  } csm_boot_t;

  typedef enum logic
  {
    CSM_MODE_THREAD,
    CSM_MODE_HANDLER
  } csm_mode_t;

endpackage

/* File: csm_le_lane.sv */
// Little-endian lane extractor for byte, halfword and word loads.
// Assumes a naturally aligned access; a misaligned one is trimmed.
`timescale 1ns/1ps
`include "csm_regs_map.svh"

module csm_le_lane
  import csm_pkg::*;
(
  input  wire logic [31:0] word,
  input  wire logic [1:0]  addr,
  input  wire logic [1:0]  size,
  output logic      [31:0] value
);

  logic [31:0] shifted;

  // Lowest address holds the least significant byte
  always_comb
  begin
    shifted = word >> {addr, 3'h0};
    value   = shifted;
    if (size == `CSM_SIZE_BYTE)
    begin
      value = {24'h000000, shifted[7:0]};
    end
    else if (size == `CSM_SIZE_HALF)
    begin
      value = {16'h0000, shifted[15:0]};
    end
  end

endmodule

/* File: csm_regs_props.sv */
// Concurrent checks on the special register group's ports.
// Bound into csm_regs; sees only that module's top-level ports.
`timescale 1ns/1ps
`include "csm_regs_map.svh"

module csm_regs_props
(
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic        SR_RD,
  input wire logic [2:0]  SR_SEL,
  input wire logic [31:0] SR_RDATA,
  input wire logic        EXC_ENTRY,
  input wire logic        EXC_REQ,
  input wire logic        EXC_PRIO_CFG,
  input wire logic        EXC_ALLOW,
  input wire logic        MASK_ACTIVE,
  input wire logic        INSTR_EXEC,
  input wire logic        T_STATE,
  input wire logic        HARD_FAULT_REQ,
  input wire logic        LOCKUP,
  input wire logic        IRQ_TAKEN,
  input wire logic        MULT_BUSY,
  input wire logic [31:0] MULT_PC,
  input wire logic        MULT_ABANDON,
  input wire logic [31:0] STACKED_RET_PC,
  input wire logic        BOOT_REQ,
  input wire logic        BOOT_ACK,
  input wire logic [31:0] BOOT_ADDR,
  input wire logic        MAIN_SP_LOAD,
  input wire logic        PC_LOAD,
  input wire logic [31:0] BOOT_VALUE,
  input wire logic        HANDLER_MODE,
  input wire logic        PROCESS_SP
);
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // Status views lag a cycle, so checks pairing a view with an input require the view to hold twice
  a_exec_reads_zero: assert property (
    SR_RD && SR_SEL == `CSM_SEL_EXEC_STATE |=> SR_RDATA == 32'h0)
    else $error("exec state read not zero");
  a_handler_sel_zero: assert property (
    SR_RD && SR_SEL == `CSM_SEL_STACK_CTRL && HANDLER_MODE ##1 HANDLER_MODE
    |-> !SR_RDATA[1]) else $error("stack select visible in handler");
  a_mask_blocks: assert property (
    EXC_REQ && EXC_PRIO_CFG && MASK_ACTIVE ##1 MASK_ACTIVE |-> !EXC_ALLOW)
    else $error("masked request allowed");
  a_fixed_prio_free: assert property (
    EXC_REQ && !EXC_PRIO_CFG |=> EXC_ALLOW)
    else $error("fixed priority request blocked");
  a_state_fault: assert property (
    INSTR_EXEC && !T_STATE ##1 !T_STATE |-> HARD_FAULT_REQ || LOCKUP)
    else $error("no fault on clear state bit");
  a_abandon_pc: assert property (
    IRQ_TAKEN && MULT_BUSY && !BOOT_REQ
    |=> MULT_ABANDON && STACKED_RET_PC == $past(MULT_PC))
    else $error("multiple transfer not abandoned");
  a_boot_sp_load: assert property (
    BOOT_REQ && BOOT_ACK && BOOT_ADDR == `CSM_VEC_SP_ADDR
    |=> MAIN_SP_LOAD && BOOT_ADDR == `CSM_VEC_PC_ADDR)
    else $error("stack pointer word not loaded");
  a_boot_state_bit: assert property (
    PC_LOAD |-> ##2 T_STATE == BOOT_VALUE[0])
    else $error("state bit not from vector");
  a_handler_main_sp: assert property (
    HANDLER_MODE |-> !PROCESS_SP) else $error("process stack in handler");

  // Main scenarios reached
  c_entry: cover property (EXC_ENTRY ##2 HANDLER_MODE);
  c_abandon: cover property (MULT_ABANDON);
  c_lockup: cover property (LOCKUP);
endmodule

bind csm_regs csm_regs_props i_props (.*);

/* File: csm_regs_tb_top.sv */
// Self-checking bench for the special register group.
// Drives every csm_regs input itself; no far-side model is used.
`timescale 1ns/1ps
`include "csm_regs_map.svh"

module csm_regs_tb_top;
  logic MCLK, RESET_N = 1'b0, SR_RD = 0, SR_WR = 0, CPS_EN = 0;
  logic CPS_DISABLE = 0, EXC_ENTRY = 0, VECTOR_BIT0 = 0, EXC_RETURN = 0;
  logic RET_TO_THREAD = 0, RET_SP_SEL = 0, BX_LOAD = 0, BX_TBIT = 0;
  logic INSTR_EXEC = 0, EXC_REQ = 0, EXC_PRIO_CFG = 0, MULT_BUSY = 0;
  logic IRQ_TAKEN = 0, BOOT_ACK = 0, DATA_RD = 0;
  logic [2:0]  SR_SEL = '0;
  logic [5:0]  EXC_NUM = '0;
  logic [1:0]  DATA_ADDR = '0, DATA_SIZE = '0;
  logic [31:0] SR_WDATA = '0, RET_PSR = '0, MULT_PC = '0;
  logic [31:0] BOOT_RDATA = '0, DATA_WORD = '0;
  logic [31:0] SR_RDATA, STACKED_PSR, STACKED_RET_PC, BOOT_ADDR;
  logic [31:0] BOOT_VALUE, DATA_VALUE;
  logic SR_RVALID, HARD_FAULT_REQ, LOCKUP, EXC_ALLOW, MULT_ABANDON;
  logic RESTART_FIRST, BOOT_REQ, MAIN_SP_LOAD, PC_LOAD, HANDLER_MODE;
  logic PROCESS_SP, MASK_ACTIVE, T_STATE;
  int   n_mismatch = 0;
  int   total_checks = 0;
  localparam int ENT = 0, RET = 1, BXL = 2, EXE = 3, IRQ = 4, CHANGE_PROCESSOR_STATE = 5;
  localparam int DRD = 6;
  logic [31:0] dexp [7] = '{32'h11, 32'h22, 32'h33, 32'h44, 32'h2211,
                            32'h4433, 32'h4433_2211};

  csm_regs i_dut (.*);

  // Free-running core clock, 4 ns period
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobe; directly registered outputs are settled when the task returns, status views a cycle later
  task automatic strobe(input int w);
    @(posedge MCLK);
    case (w)
      ENT: EXC_ENTRY <= 1'b1;
      RET: EXC_RETURN <= 1'b1;
      BXL: BX_LOAD <= 1'b1;
      EXE: INSTR_EXEC <= 1'b1;
      IRQ: IRQ_TAKEN <= 1'b1;
      CHANGE_PROCESSOR_STATE: CPS_EN <= 1'b1;
      default: DATA_RD <= 1'b1;
    endcase
    @(posedge MCLK);
    {EXC_ENTRY, EXC_RETURN, BX_LOAD, INSTR_EXEC} <= 4'h0;
    {IRQ_TAKEN, CPS_EN, DATA_RD} <= 3'h0;
    #1;
  endtask

  // Bounded poll; a hang ends the run as a failure
  task automatic wait_for(input int w);
    for (int i = 0; i < 40; i++)
    begin
      #1;
      if (((w == 0) ? BOOT_REQ : (w == 1) ? MAIN_SP_LOAD : PC_LOAD) === 1'b1)
        return;
      @(posedge MCLK);
    end
    n_mismatch++;
    wrap_up();
  endtask

  // Released fetch data is inverted so a stale value cannot pass
  task automatic ack(input logic [31:0] d);
    @(posedge MCLK);
    BOOT_ACK <= 1'b1;
    BOOT_RDATA <= d;
    @(posedge MCLK);
    BOOT_ACK <= 1'b0;
    BOOT_RDATA <= ~d;
  endtask

  task automatic sr_wr(input logic [2:0] sel, input logic [31:0] d);
    @(posedge MCLK);
    SR_WR <= 1'b1;
    SR_SEL <= sel;
    SR_WDATA <= d;
    @(posedge MCLK);
    SR_WR <= 1'b0;
    SR_WDATA <= ~d;
  endtask

  task automatic sr_rd(input logic [2:0] sel, input logic [31:0] exp);
    @(posedge MCLK);
    SR_RD <= 1'b1;
    SR_SEL <= sel;
    @(posedge MCLK);
    SR_RD <= 1'b0;
    #1;
    chk({31'h0, SR_RVALID}, 32'h1);
    chk(SR_RDATA, exp);
  endtask

  task automatic req(input logic cfg, input logic exp);
    @(posedge MCLK);
    EXC_REQ <= 1'b1;
    EXC_PRIO_CFG <= cfg;
    repeat (2) @(posedge MCLK);
    EXC_REQ <= 1'b0;
    #1;
    chk({31'h0, EXC_ALLOW}, {31'h0, exp});
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge MCLK);
    RESET_N <= 1'b1;
    wait_for(0);
    chk(BOOT_ADDR, `CSM_VEC_SP_ADDR);
    ack(32'h2000_0400);
    wait_for(1);
    chk(BOOT_ADDR, `CSM_VEC_PC_ADDR);
    ack(32'h0000_0101);
    wait_for(2);
    chk(BOOT_VALUE, 32'h0000_0101);
    $display("Boot test done");
    sr_rd(`CSM_SEL_STACK_CTRL, 32'h0);
    sr_wr(`CSM_SEL_INTR_STATUS, 32'h0000_003F);
    sr_wr(`CSM_SEL_EXEC_STATE, 32'h0);
    sr_rd(`CSM_SEL_INTR_STATUS, 32'h0);
    sr_rd(`CSM_SEL_EXEC_STATE, 32'h0);
    chk({31'h0, T_STATE}, 32'h1);
    $display("Read-only test done");
    sr_wr(`CSM_SEL_PRIO_MASK, 32'hFFFF_FFFF);
    sr_rd(`CSM_SEL_PRIO_MASK, 32'h1);
    chk({31'h0, MASK_ACTIVE}, 32'h1);
    req(1'b1, 1'b0);
    req(1'b0, 1'b1);
    strobe(CHANGE_PROCESSOR_STATE);
    sr_rd(`CSM_SEL_PRIO_MASK, 32'h0);
    chk({31'h0, MASK_ACTIVE}, 32'h0);
    req(1'b1, 1'b1);
    // State change can also set the mask, not only clear it
    @(posedge MCLK) CPS_DISABLE <= 1'b1;
    strobe(CHANGE_PROCESSOR_STATE);
    sr_rd(`CSM_SEL_PRIO_MASK, 32'h1);
    $display("Mask test done");
    sr_wr(`CSM_SEL_STACK_CTRL, 32'hFFFF_FFFF);
    // Barrier slot: nothing uses the stack until the new select settles
    @(posedge MCLK);
    sr_rd(`CSM_SEL_STACK_CTRL, 32'h2);
    chk({31'h0, PROCESS_SP}, 32'h1);
    @(posedge MCLK);
    MULT_BUSY <= 1'b1;
    MULT_PC <= 32'h0000_1234;
    strobe(IRQ);
    chk({MULT_ABANDON, STACKED_RET_PC[30:0]}, 32'h8000_1234);
    @(posedge MCLK);
    MULT_BUSY <= 1'b0;
    EXC_NUM <= `CSM_EXC_IRQ_FIRST;
    VECTOR_BIT0 <= 1'b1;
    strobe(ENT);
    chk(STACKED_PSR, 32'h0100_0000);
    @(posedge MCLK);
    #1;
    chk({30'h0, HANDLER_MODE, PROCESS_SP}, 32'h2);
    sr_rd(`CSM_SEL_INTR_STATUS, 32'h10);
    sr_rd(`CSM_SEL_PROG_STATUS, 32'h10);
    sr_wr(`CSM_SEL_STACK_CTRL, 32'h2);
    sr_rd(`CSM_SEL_STACK_CTRL, 32'h0);
    chk({31'h0, PROCESS_SP}, 32'h0);
    @(posedge MCLK);
    RET_PSR <= 32'h0100_0000;
    RET_TO_THREAD <= 1'b1;
    RET_SP_SEL <= 1'b1;
    strobe(RET);
    chk({31'h0, RESTART_FIRST}, 32'h1);
    @(posedge MCLK);
    #1;
    chk({30'h0, HANDLER_MODE, PROCESS_SP}, 32'h1);
    sr_rd(`CSM_SEL_INTR_STATUS, 32'h0);
    $display("Exception test done");
    @(posedge MCLK) BX_TBIT <= 1'b0;
    strobe(BXL);
    strobe(EXE);
    chk({30'h0, HARD_FAULT_REQ, LOCKUP}, 32'h2);
    @(posedge MCLK) BX_TBIT <= 1'b1;
    strobe(BXL);
    strobe(EXE);
    chk({31'h0, HARD_FAULT_REQ}, 32'h0);
    @(posedge MCLK) DATA_WORD <= 32'h4433_2211;
    // Every byte lane, both halfword lanes, then the full word
    for (int i = 0; i < 7; i++)
    begin
      @(posedge MCLK);
      DATA_SIZE <= (i < 4) ? `CSM_SIZE_BYTE
                 : (i < 6) ? `CSM_SIZE_HALF : `CSM_SIZE_WORD;
      DATA_ADDR <= (i < 4) ? i[1:0] : (i == 5) ? 2'h2 : 2'h0;
      strobe(DRD);
      chk(DATA_VALUE, dexp[i]);
    end
    $display("Lane test done");
    // Lockup is sticky, so this runs last
    @(posedge MCLK);
    EXC_NUM <= `CSM_EXC_NMI;
    VECTOR_BIT0 <= 1'b0;
    strobe(ENT);
    repeat (2) @(posedge MCLK);
    strobe(EXE);
    chk({30'h0, LOCKUP, T_STATE}, 32'h2);
    $display("Lockup test done");
    wrap_up();
  end
endmodule
